// ===== shared/supervisor_regs.svh
/*
 * Register offsets, field positions, reset values and timing figures
 * of the supervisor block.
 * Assumes a 20 MHz pclk and a 32-bit APB register bus.
 */
`ifndef SUPERVISOR_REGS_SVH
`define SUPERVISOR_REGS_SVH

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define SV_ADDR_CTRL 12'h000
`define SV_ADDR_STATUS 12'h004
`define SV_ADDR_WDCNT 12'h008

`define SV_CTRL_WDEN_BIT 0
`define SV_CTRL_RST 1'h1

`define SV_ST_LL_BIT 0
`define SV_ST_RSTN_BIT 1
`define SV_ST_WDON_BIT 2
`define SV_ST_PFN_BIT 3
`define SV_ST_BKUP_BIT 4
`define SV_ST_MAIN_BIT 5
`define SV_ST_FIRST_BIT 6

// ----------------------------------------------------------------
// Pin vector layout and synchroniser reset values
// ----------------------------------------------------------------
`define SV_NPIN 9
`define SV_PIN_LL 0
`define SV_PIN_PF 1
`define SV_PIN_KICK 2
`define SV_PIN_WFLT 3
`define SV_PIN_OSEL 4
`define SV_PIN_TBIN 5
`define SV_PIN_EXT 6
`define SV_PIN_CEIN 7
`define SV_PIN_MAIN 8
`define SV_SYNC_RST 9'h0B8

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SV_CLK_KHZ 20000
`define SV_RST_DELAY_MS 50
`define SV_WD_LONG_MS 1600
`define SV_WD_SHORT_MS 100
`define SV_WD_EXT_EDGES 1024

`endif

// ===== shared/supervisor_pkg.sv
/*
 * Types shared by the supervisor block.
 * Assumes supervisor_regs.svh for all numeric constants.
 */
package supervisor_pkg;
	typedef enum logic [1:0] {
		RST_HOLD,
		RST_DELAY,
		RST_IDLE
	} rst_state_t;
	typedef logic [31:0] word_t;
	typedef logic [11:0] addr_t;
endpackage

// ===== core/supervisor_watchdog_reset.sv
/*
 * Processor supervisor: low-line reset with release delay, watchdog,
 * power-fail flag, chip enable gating, supply switch and APB status.
 * Assumes comparator flags arrive as asynchronous logic levels, with
 * 1 meaning the sensed level is above its threshold.
 */
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "supervisor_regs.svh"

module supervisor_watchdog_reset #(
	parameter int RST_CYCLES = `SV_RST_DELAY_MS * `SV_CLK_KHZ,
	parameter int WD_LONG_CYCLES = `SV_WD_LONG_MS * `SV_CLK_KHZ,
	parameter int WD_SHORT_CYCLES = `SV_WD_SHORT_MS * `SV_CLK_KHZ,
	parameter int WD_EXT_EDGES = `SV_WD_EXT_EDGES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire supervisor_pkg::addr_t paddr,
	input wire supervisor_pkg::word_t pwdata,
	output supervisor_pkg::word_t prdata,
	output logic pready,
	output logic pslverr,
	input wire logic low_line_sense,
	input wire logic power_fail_sense,
	input wire logic watchdog_toggle_input,
	input wire logic watchdog_toggle_floating,
	input wire logic timebase_source_select,
	input wire logic timebase_input,
	input wire logic external_timebase,
	input wire logic chip_enable_in_n,
	input wire logic main_above_backup,
	output logic reset_n,
	output logic watchdog_timeout_flag_n,
	output logic power_fail_flag_n,
	output logic chip_enable_out_n,
	output logic backup_active_indicator,
	output logic supply_on_backup
);
	import supervisor_pkg::*;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	localparam int NP = `SV_NPIN;
	logic [NP-1:0] pins;
	logic [NP-1:0] s1_r, s2_r, s3_r, flt_r;
	logic [NP-1:0] s1_nxt, s2_nxt, s3_nxt, flt_nxt;

	assign pins = {main_above_backup, chip_enable_in_n, external_timebase,
		timebase_input, timebase_source_select, watchdog_toggle_floating,
		watchdog_toggle_input, power_fail_sense, low_line_sense};

	always_comb begin
		s1_nxt = pins;
		s2_nxt = s1_r;
		s3_nxt = s2_r;
		flt_nxt = (flt_r & (s2_r ^ s3_r)) | (s3_r & ~(s2_r ^ s3_r));
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_r <= `SV_SYNC_RST;
			s2_r <= `SV_SYNC_RST;
			s3_r <= `SV_SYNC_RST;
			flt_r <= `SV_SYNC_RST;
		end else begin
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
			s3_r <= s3_nxt;
			flt_r <= flt_nxt;
		end
	end

	logic ll_ok, pf_ok, kick_f, wflt_f, osel_f, tbin_f, ext_f, cein_f;
	logic main_f;
	assign ll_ok = flt_r[`SV_PIN_LL];
	assign pf_ok = flt_r[`SV_PIN_PF];
	assign kick_f = flt_r[`SV_PIN_KICK];
	assign wflt_f = flt_r[`SV_PIN_WFLT];
	assign osel_f = flt_r[`SV_PIN_OSEL];
	assign tbin_f = flt_r[`SV_PIN_TBIN];
	assign ext_f = flt_r[`SV_PIN_EXT];
	assign cein_f = flt_r[`SV_PIN_CEIN];
	assign main_f = flt_r[`SV_PIN_MAIN];

	// ------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------
	logic ctrl_wden_r, ctrl_wden_nxt;
	logic pready_nxt, pslverr_nxt;
	word_t prdata_nxt;
	logic [25:0] wd_cnt_r, wd_cnt_nxt;
	logic first_r, first_nxt;

	function automatic logic addr_hit(input addr_t a);
		addr_hit = (a == `SV_ADDR_CTRL) || (a == `SV_ADDR_STATUS) ||
			(a == `SV_ADDR_WDCNT);
	endfunction

	always_comb begin
		ctrl_wden_nxt = ctrl_wden_r;
		pready_nxt = 1'b0;
		pslverr_nxt = 1'b0;
		prdata_nxt = prdata;
		if (psel && penable && !pready) begin
			pready_nxt = 1'b1;
			pslverr_nxt = !addr_hit(paddr);
			prdata_nxt = 32'h00000000;
			if (pwrite) begin
				if (paddr == `SV_ADDR_CTRL)
					ctrl_wden_nxt = pwdata[`SV_CTRL_WDEN_BIT];
			end else begin
				case (paddr)
				`SV_ADDR_CTRL: prdata_nxt[`SV_CTRL_WDEN_BIT] = ctrl_wden_r;
				`SV_ADDR_STATUS: begin
					prdata_nxt[`SV_ST_LL_BIT] = ll_ok;
					prdata_nxt[`SV_ST_RSTN_BIT] = reset_n;
					prdata_nxt[`SV_ST_WDON_BIT] = watchdog_timeout_flag_n;
					prdata_nxt[`SV_ST_PFN_BIT] = power_fail_flag_n;
					prdata_nxt[`SV_ST_BKUP_BIT] = supply_on_backup;
					prdata_nxt[`SV_ST_MAIN_BIT] = main_f;
					prdata_nxt[`SV_ST_FIRST_BIT] = first_r;
				end
				`SV_ADDR_WDCNT: prdata_nxt = {6'h00, wd_cnt_r};
				default: prdata_nxt = 32'h00000000;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_wden_r <= `SV_CTRL_RST;
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			ctrl_wden_r <= ctrl_wden_nxt;
			pready <= pready_nxt;
			pslverr <= pslverr_nxt;
			prdata <= prdata_nxt;
		end
	end

	// ------------------------------------------------------------
	// Watchdog
	// ------------------------------------------------------------
	logic kick_d_r, ext_d_r, kick_edge, ext_edge, wd_run, wd_inc;
	logic wd_expire, tflag_nxt;
	logic [25:0] wd_limit;
	rst_state_t rst_r, rst_nxt;

	assign kick_edge = kick_f != kick_d_r;
	assign ext_edge = ext_f != ext_d_r;
	// floating input or software disable stops it
	assign wd_run = !wflt_f && ctrl_wden_r && rst_r == RST_IDLE;

	always_comb begin
		wd_limit = WD_EXT_EDGES[25:0];
		wd_inc = ext_edge;
		if (first_r) begin
			wd_limit = WD_LONG_CYCLES[25:0];
			wd_inc = 1'b1;
		end else if (osel_f) begin
			wd_limit = tbin_f ? WD_LONG_CYCLES[25:0] : WD_SHORT_CYCLES[25:0];
			wd_inc = 1'b1;
		end
	end

	// timeout when the limit is reached
	assign wd_expire = wd_run && !kick_edge && wd_inc &&
		wd_cnt_r == wd_limit - 26'h0000001;

	always_comb begin
		wd_cnt_nxt = wd_cnt_r;
		first_nxt = first_r;
		tflag_nxt = watchdog_timeout_flag_n;
		if (!wd_run) begin
			wd_cnt_nxt = 26'h0000000;
		end else if (kick_edge) begin
			wd_cnt_nxt = 26'h0000000;
		end else if (wd_expire) begin
			wd_cnt_nxt = 26'h0000000;
		end else if (wd_inc) begin
			wd_cnt_nxt = wd_cnt_r + 26'h0000001;
		end
		if (rst_r != RST_IDLE)
			first_nxt = 1'b1;
		else if (kick_edge && wd_run)
			first_nxt = 1'b0;
		// flag low until the next toggle or a low line
		if (wd_expire)
			tflag_nxt = 1'b0;
		else if (kick_edge || !ll_ok)
			tflag_nxt = 1'b1;
	end

	// ------------------------------------------------------------
	// Reset generator and pin outputs
	// ------------------------------------------------------------
	logic [19:0] rst_cnt_r, rst_cnt_nxt;

	// hold, then fixed delay after recovery
	always_comb begin
		rst_nxt = rst_r;
		rst_cnt_nxt = 20'h00000;
		case (rst_r)
		RST_HOLD: if (ll_ok) rst_nxt = RST_DELAY;
		RST_DELAY: begin
			rst_cnt_nxt = rst_cnt_r + 20'h00001;
			if (rst_cnt_r == RST_CYCLES[19:0] - 20'h00001)
				rst_nxt = RST_IDLE;
		end
		RST_IDLE: if (wd_expire) rst_nxt = RST_DELAY;
		default: rst_nxt = RST_HOLD;
		endcase
		if (!ll_ok) begin
			rst_nxt = RST_HOLD;
			rst_cnt_nxt = 20'h00000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rst_r <= RST_HOLD;
			rst_cnt_r <= 20'h00000;
			wd_cnt_r <= 26'h0000000;
			first_r <= 1'b1;
			kick_d_r <= 1'b0;
			ext_d_r <= 1'b0;
			reset_n <= 1'b0;
			watchdog_timeout_flag_n <= 1'b1;
			power_fail_flag_n <= 1'b0;
			chip_enable_out_n <= 1'b1;
			backup_active_indicator <= 1'b0;
			supply_on_backup <= 1'b0;
		end else begin
			rst_r <= rst_nxt;
			rst_cnt_r <= rst_cnt_nxt;
			wd_cnt_r <= wd_cnt_nxt;
			first_r <= first_nxt;
			kick_d_r <= kick_f;
			ext_d_r <= ext_f;
			reset_n <= rst_nxt == RST_IDLE;
			watchdog_timeout_flag_n <= tflag_nxt;
			power_fail_flag_n <= pf_ok;
			// gate chip enable on low line
			chip_enable_out_n <= ll_ok ? cein_f : 1'b1;
			backup_active_indicator <= !ll_ok && !main_f;
			// switch to backup on low line with main below backup
			supply_on_backup <= !ll_ok && !main_f;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	sequence seq_expire;
		wd_expire;
	endsequence
	sequence seq_pulse;
		!reset_n && !watchdog_timeout_flag_n ##1 !reset_n;
	endsequence

	AST_RST_LOW: assert property (@(posedge pclk) disable iff (!presetn)
		!ll_ok |=> !reset_n) else $error("reset not held on low line");
	AST_RST_DELAY: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(reset_n) |-> $past(rst_cnt_r) == RST_CYCLES[19:0] - 20'h00001)
		else $error("reset released early");
	AST_WD_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
		seq_expire |=> seq_pulse) else $error("no reset on timeout");
	AST_WD_FLOAT: assert property (@(posedge pclk) disable iff (!presetn)
		wflt_f |=> wd_cnt_r == 26'h0000000 && !wd_expire)
		else $error("watchdog ran while floating");
	AST_CE_GATE: assert property (@(posedge pclk) disable iff (!presetn)
		1'b1 |=> chip_enable_out_n == ($past(ll_ok) ? $past(cein_f) : 1'b1))
		else $error("chip enable gating wrong");
	AST_PF_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
		1'b1 |=> power_fail_flag_n == $past(pf_ok))
		else $error("power fail flag wrong");
	AST_BATT_IND: assert property (@(posedge pclk) disable iff (!presetn)
		main_f |=> !backup_active_indicator) else $error("indicator high");
	AST_SUPPLY: assert property (@(posedge pclk) disable iff (!presetn)
		ll_ok |=> !supply_on_backup) else $error("backup in normal run");
	AST_FIRST: assert property (@(posedge pclk) disable iff (!presetn)
		!reset_n ##1 reset_n |-> first_r) else $error("short after reset");
	AST_HOLD_LOW: assert property (@(posedge pclk) disable iff (!presetn)
		!watchdog_timeout_flag_n && !kick_edge && ll_ok |=>
		!watchdog_timeout_flag_n) else $error("timeout flag released");
	AST_KICK: assert property (@(posedge pclk) disable iff (!presetn)
		kick_edge && wd_run |=> wd_cnt_r == 26'h0000000)
		else $error("toggle did not restart");
	AST_SYNC: assert property (@(posedge pclk) disable iff (!presetn)
		$changed(flt_r) |-> ((flt_r ^ $past(flt_r)) &
		(($past(s2_r) ^ $past(s3_r)) | (flt_r ^ $past(s3_r)))) == '0)
		else $error("filter changed without agreement");
endmodule

// ===== verification/supervisor_proc_model.sv
/*
 * Processor model: drives the watchdog toggle line.
 * Assumes the bench starts, stops and slows it via run and slow.
 */
`timescale 1ns/1ps
module supervisor_proc_model #(
	parameter int HALF = 15
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic run,
	input wire logic slow,
	output logic toggle
);
	int cnt;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 0;
			toggle <= 1'b0;
		end else if (run) begin
			if (cnt >= (slow ? 3 * HALF : HALF) - 1) begin
				cnt <= 0;
				toggle <= ~toggle;
			end else begin
				cnt <= cnt + 1;
			end
		end
	end
endmodule

// ===== verification/supervisor_watchdog_reset_tb_top.sv
/*
 * Self-checking bench: pins, watchdog modes and APB registers.
 * Assumes short timing parameters and the processor model.
 */
`timescale 1ns/1ps
`include "supervisor_regs.svh"
module supervisor_watchdog_reset_tb_top;
	import supervisor_pkg::*;
	localparam int RST = 20;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	addr_t paddr = '0;
	word_t pwdata = '0, prdata, q;
	logic pready, pslverr, e, run = 0, slow = 0, ext_run = 0;
	logic ll = 0, pf = 0, kick, flt = 1, osel = 1, tbin = 1, ext = 0;
	logic ce = 1, main_ok = 1, rst_out_n, tflag_n, pf_n, ce_out_n, ind, bkup;
	int miscompares = 0, tests_run = 0, n, ecnt = 0;

	always #25 pclk = ~pclk;
	// Slow external timing source
	always @(posedge pclk) begin
		ecnt <= ecnt + 1;
		if (ext_run && ecnt % 4 == 0)
			ext <= ~ext;
	end

	supervisor_watchdog_reset #(.RST_CYCLES(RST), .WD_LONG_CYCLES(100),
		.WD_SHORT_CYCLES(40), .WD_EXT_EDGES(8)) i_dut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.low_line_sense(ll), .power_fail_sense(pf),
		.watchdog_toggle_input(kick), .watchdog_toggle_floating(flt),
		.timebase_source_select(osel), .timebase_input(tbin),
		.external_timebase(ext), .chip_enable_in_n(ce),
		.main_above_backup(main_ok), .reset_n(rst_out_n),
		.watchdog_timeout_flag_n(tflag_n), .power_fail_flag_n(pf_n),
		.chip_enable_out_n(ce_out_n), .backup_active_indicator(ind),
		.supply_on_backup(bkup));
	supervisor_proc_model #(.HALF(15)) i_proc (.clk(pclk),
		.rst_n(presetn), .run(run), .slow(slow), .toggle(kick));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic chk(input word_t seen, input word_t exp, input string nm);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic idle(input int k);
		repeat (k) @(posedge pclk);
	endtask
	task automatic wait_lvl(input int w, input logic v, input int lim);
		n = 0;
		while (n < lim && (w ? rst_out_n : tflag_n) !== v) begin
			@(posedge pclk);
			n++;
		end
	endtask
	task automatic apb(input addr_t a, input logic w, input word_t d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		q = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
		if (k >= 20)
			miscompares++;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_lowline;
		idle(10);
		chk(rst_out_n, 0, "reset_n held");
		ll <= 1;
		wait_lvl(1, 1, 60);
		chk(n >= RST && n <= RST + 8, 1, "release delay");
		ll <= 0;
		@(posedge pclk);
		ll <= 1;
		idle(10);
		chk(rst_out_n, 1, "glitch filtered");
		$display("test lowline done");
	endtask
	task automatic t_pins;
		for (int i = 0; i < 16; i++) begin
			{ce, main_ok, pf, ll} <= 4'(i);
			idle(8);
			chk(pf_n, pf, "pf flag");
			chk(ce_out_n, ll ? ce : 1'b1, "ce out");
			chk(ind, !ll && !main_ok, "indicator");
			chk(bkup, !ll && !main_ok, "supply");
		end
		wait_lvl(1, 1, 60);
		$display("test pins done");
	endtask
	task automatic t_apb;
		apb(`SV_ADDR_CTRL, 0, '0);
		chk(q, 1, "ctrl reset");
		apb(`SV_ADDR_STATUS, 0, '0);
		chk(q[6:0], 7'h6F, "status");
		apb(12'h00C, 1, 32'h1);
		chk(e, 1, "unmapped write");
		apb(12'h00C, 0, '0);
		chk(q, 0, "unmapped read");
		$display("test apb done");
	endtask
	task automatic t_short;
		flt <= 0;
		tbin <= 0;
		run <= 1;
		wait_lvl(0, 0, 300);
		chk(n, 300, "fast toggles");
		run <= 0;
		wait_lvl(0, 0, 80);
		chk(n >= 30 && n <= 48, 1, "short timeout");
		wait_lvl(1, 0, 3);
		chk(rst_out_n, 0, "wd reset");
		wait_lvl(1, 1, 40);
		chk(tflag_n, 0, "flag held");
		wait_lvl(1, 0, 130);
		chk(n >= 90 && n <= 110, 1, "first period");
		wait_lvl(1, 1, 40);
		tbin <= 1;
		slow <= 1;
		run <= 1;
		wait_lvl(0, 1, 80);
		chk(tflag_n, 1, "flag cleared");
		wait_lvl(0, 0, 300);
		chk(n, 300, "long period");
		slow <= 0;
		$display("test short done");
	endtask
	task automatic t_ext;
		osel <= 0;
		idle(20);
		run <= 0;
		wait_lvl(0, 0, 150);
		chk(n, 150, "ext frozen");
		ext_run <= 1;
		wait_lvl(0, 0, 60);
		chk(n >= 25 && n < 60, 1, "ext timeout");
		ext_run <= 0;
		osel <= 1;
		wait_lvl(1, 1, 40);
		run <= 1;
		wait_lvl(0, 1, 40);
		$display("test ext done");
	endtask
	task automatic t_disable;
		run <= 0;
		flt <= 1;
		wait_lvl(0, 0, 200);
		chk(n, 200, "floating");
		apb(`SV_ADDR_CTRL, 1, '0);
		flt <= 0;
		wait_lvl(0, 0, 200);
		chk(n, 200, "ctrl off");
		apb(`SV_ADDR_WDCNT, 0, '0);
		chk(q, 0, "count held");
		chk(e, 0, "mapped read");
		apb(`SV_ADDR_CTRL, 0, '0);
		chk(q, 0, "ctrl rw");
		$display("test disable done");
	endtask

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1;
		t_lowline;
		t_pins;
		t_apb;
		t_short;
		t_ext;
		t_disable;
		report_and_stop;
	end
	initial begin
		#(50 * 5000);
		miscompares++;
		report_and_stop;
	end
endmodule
